// File: common/atr_pkg.sv
package atr_pkg;
	// =====================================================
	// Register map (printed offsets are indices; byte address = 4 x index)
	localparam logic [11:0] ATR_IDX_WORD_ONE = 12'h00a0;
	localparam logic [11:0] ATR_IDX_WORD_TWO = 12'h00a2;
	localparam logic [11:0] ATR_IDX_STATUS = 12'h00a3;
	localparam logic [11:0] ATR_ADDR_WORD_ONE = ATR_IDX_WORD_ONE << 2;
	localparam logic [11:0] ATR_ADDR_WORD_TWO = ATR_IDX_WORD_TWO << 2;
	localparam logic [11:0] ATR_ADDR_STATUS = ATR_IDX_STATUS << 2;
	localparam logic [31:0] ATR_RST_WORD = 32'h0000_0000;
	localparam int ATR_PARITY_BIT = 31;

	// =====================================================
	// Clock and timing
	localparam int ATR_CLK_MHZ = 25;
	localparam int ATR_GLITCH_NS [4] = '{0, 200, 500, 1000};

	// =====================================================
	// Code tables
	localparam logic [7:0] ATR_BRAKE_EXIT_PERMILLE [4] = '{8'h19, 8'h32, 8'h4b, 8'h64};
	localparam logic [7:0] ATR_PERSIST_MS [4] = '{8'h01, 8'h05, 8'h32, 8'h64};
	localparam logic [11:0] ATR_TIMEOUT_MS [4] = '{12'h01f4, 12'h02ee, 12'h03e8, 12'h07d0};
	localparam logic [11:0] ATR_BEMF_MV [8] = '{12'h0000, 12'h0064, 12'h00c8, 12'h01f4,
		12'h03e8, 12'h07d0, 12'h09c4, 12'h0bb8};
	localparam logic [7:0] ATR_SPEED_PCT [4] = '{8'h0f, 8'h19, 8'h23, 8'h32};
	localparam logic [7:0] ATR_ACCEL_DHZ [8] = '{8'h01, 8'h05, 8'h0a, 8'h14, 8'h1e, 8'h32, 8'h64, 8'hc8};
	localparam logic [7:0] ATR_DECEL_PCT [8] = '{8'h32, 8'h3c, 8'h46, 8'h50, 8'h5a, 8'h64, 8'h7d, 8'h96};
	localparam logic [7:0] ATR_CURR_STEP_PCT = 8'h0a;

	// =====================================================
	// Field layout of the first tuning word
	typedef struct packed {
		logic parity;
		logic [1:0] brake_exit_sel;
		logic [1:0] glitch_filter_sel;
		logic quick_spin_detect_on;
		logic [1:0] stopped_persist_sel;
		logic [1:0] running_persist_sel;
		logic [1:0] spin_detect_timeout_sel;
		logic [2:0] handoff_min_back_emf_sel;
		logic [5:0] reserved;
		logic [2:0] estimation_current_ref_sel;
		logic [1:0] estimation_speed_ref_sel;
		logic [2:0] estimation_accel_sel;
		logic [2:0] reverse_decel_scale_sel;
	} atr_word_one_type;

	// Settings decoded into physical units for the algorithm engines
	typedef struct packed {
		logic [7:0] brake_exit_permille;
		logic [7:0] glitch_cycles;
		logic quick_spin_detect_on;
		logic [7:0] stopped_persist_ms;
		logic [7:0] running_persist_ms;
		logic [11:0] spin_detect_timeout_ms;
		logic [11:0] handoff_min_back_emf_mv;
		logic [7:0] estimation_current_pct;
		logic [7:0] estimation_speed_pct;
		logic [7:0] estimation_accel_dhz;
		logic [7:0] reverse_decel_pct;
	} atr_decoded_type;
endpackage

// File: src/atr_bank.sv
`timescale 1ns/1ps
module atr_bank import atr_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Settings to the algorithm engines
	output atr_word_one_type word_one,
	output logic [31:0] word_two,
	output atr_decoded_type decoded
);

	// =====================================================
	// Bus decode
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	atr_word_one_type word_one_r;
	logic [31:0] word_two_r;
	atr_decoded_type decoded_r;
	atr_decoded_type decoded_nxt;

	wire logic access = psel & penable;
	wire logic answer = access & ~pready_r;
	wire logic commit = access & pready_r;
	wire logic hit_one = paddr == ATR_ADDR_WORD_ONE;
	wire logic hit_two = paddr == ATR_ADDR_WORD_TWO;
	wire logic hit_stat = paddr == ATR_ADDR_STATUS;
	wire logic mapped = hit_one | hit_two | (hit_stat & ~pwrite);
	wire logic wr_one = commit & pwrite & hit_one;
	wire logic wr_two = commit & pwrite & hit_two;

	// Byte-lane merge; unmapped offsets in the group are never altered
	wire logic [31:0] one_nxt;
	wire logic [31:0] two_nxt;
	for (genvar lane = 0; lane < 4; lane++) begin : g_lane
		wire logic take = pstrb[lane];
		assign one_nxt[lane*8 +: 8] = take ? pwdata[lane*8 +: 8] : word_one_r[lane*8 +: 8];
		assign two_nxt[lane*8 +: 8] = take ? pwdata[lane*8 +: 8] : word_two_r[lane*8 +: 8];
	end

	// Parity is stored as written; status flags a word whose odd count disagrees
	wire logic [32:0] one_par_run;
	wire logic [32:0] two_par_run;
	assign one_par_run[0] = 1'b0;
	assign two_par_run[0] = 1'b0;
	for (genvar bit_i = 0; bit_i < 32; bit_i++) begin : g_par
		assign one_par_run[bit_i + 1] = one_par_run[bit_i] ^ word_one_r[bit_i];
		assign two_par_run[bit_i + 1] = two_par_run[bit_i] ^ word_two_r[bit_i];
	end
	wire logic one_par_bad = one_par_run[32];
	wire logic two_par_bad = two_par_run[32];
	wire logic [31:0] status_word = {30'h0000_0000, two_par_bad, one_par_bad};

	wire logic [31:0] rd_mux = hit_one ? word_one_r : hit_two ? word_two_r : hit_stat ? status_word : 32'h0000_0000;

	// =====================================================
	// APB answer: one wait state so that every bus output is a flop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= ATR_RST_WORD;
		end else begin
			pready_r <= answer;
			pslverr_r <= answer & ~mapped;
			prdata_r <= (answer & ~pwrite) ? rd_mux : ATR_RST_WORD;
		end
	end

	// =====================================================
	// Tuning words, taken at the edge where pready is sampled high
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_one_r <= ATR_RST_WORD;
			word_two_r <= ATR_RST_WORD;
		end else begin
			if (wr_one) begin
				word_one_r <= one_nxt;
			end
			if (wr_two) begin
				word_two_r <= two_nxt;
			end
		end
	end

	// =====================================================
	// Active-brake exit threshold in tenths of a percent
	wire logic [1:0] brake_code = word_one_r.brake_exit_sel;
	wire logic [7:0] brake_val = ATR_BRAKE_EXIT_PERMILLE[brake_code];

	// =====================================================
	// Speed pin glitch filter; rounds up to whole clocks, so never shorter than asked
	wire logic [1:0] glitch_code = word_one_r.glitch_filter_sel;
	wire logic [7:0] glitch_val = 8'((ATR_GLITCH_NS[glitch_code] * ATR_CLK_MHZ + 999) / 1000);

	// =====================================================
	// Fast initial speed detection
	wire logic quick_val = word_one_r.quick_spin_detect_on;

	// =====================================================
	// Stop and run persistence in ms
	wire logic [1:0] stop_code = word_one_r.stopped_persist_sel;
	wire logic [7:0] stop_val = ATR_PERSIST_MS[stop_code];
	wire logic [1:0] run_code = word_one_r.running_persist_sel;
	wire logic [7:0] run_val = ATR_PERSIST_MS[run_code];

	// =====================================================
	// Speed detection timeout in ms
	wire logic [1:0] timeout_code = word_one_r.spin_detect_timeout_sel;
	wire logic [11:0] timeout_val = ATR_TIMEOUT_MS[timeout_code];

	// =====================================================
	// Minimum back EMF for handoff in mV
	wire logic [2:0] bemf_code = word_one_r.handoff_min_back_emf_sel;
	wire logic [11:0] bemf_val = ATR_BEMF_MV[bemf_code];

	// =====================================================
	// Estimation current reference; linear steps, so computed rather than tabled
	wire logic [2:0] current_code = word_one_r.estimation_current_ref_sel;
	wire logic [7:0] current_val = 8'(({5'h00, current_code} + 8'h01) * ATR_CURR_STEP_PCT);

	// =====================================================
	// Estimation speed reference in percent
	wire logic [1:0] speed_code = word_one_r.estimation_speed_ref_sel;
	wire logic [7:0] speed_val = ATR_SPEED_PCT[speed_code];

	// =====================================================
	// Estimation acceleration in tenths of Hz/s
	wire logic [2:0] accel_code = word_one_r.estimation_accel_sel;
	wire logic [7:0] accel_val = ATR_ACCEL_DHZ[accel_code];

	// =====================================================
	// Reverse-drive deceleration as percent of acceleration
	wire logic [2:0] decel_code = word_one_r.reverse_decel_scale_sel;
	wire logic [7:0] decel_val = ATR_DECEL_PCT[decel_code];

	// =====================================================
	// Gather the decoded settings
	always_comb begin
		decoded_nxt.brake_exit_permille = brake_val;
		decoded_nxt.glitch_cycles = glitch_val;
		decoded_nxt.quick_spin_detect_on = quick_val;
		decoded_nxt.stopped_persist_ms = stop_val;
		decoded_nxt.running_persist_ms = run_val;
		decoded_nxt.spin_detect_timeout_ms = timeout_val;
		decoded_nxt.handoff_min_back_emf_mv = bemf_val;
		decoded_nxt.estimation_current_pct = current_val;
		decoded_nxt.estimation_speed_pct = speed_val;
		decoded_nxt.estimation_accel_dhz = accel_val;
		decoded_nxt.reverse_decel_pct = decel_val;
	end

	// Registered so the engines see a clean, glitch-free setting
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			decoded_r <= '0;
		end else begin
			decoded_r <= decoded_nxt;
		end
	end

	// =====================================================
	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign word_one = word_one_r;
	assign word_two = word_two_r;
	assign decoded = decoded_r;

endmodule

// File: testbench/atr_bank_sva.sv
`timescale 1ns/1ps
module atr_bank_sva import atr_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Settings
	input wire atr_word_one_type word_one,
	input wire logic [31:0] word_two,
	input wire atr_decoded_type decoded
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire acc = psel && penable && pready;
	wire hit1 = acc && pwrite && paddr == ATR_ADDR_WORD_ONE;
	wire mapped = paddr == ATR_ADDR_WORD_ONE || paddr == ATR_ADDR_WORD_TWO || paddr == ATR_ADDR_STATUS;
	// =====================================================
	// Bus timing and storage
	chk_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("no answer");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	chk_write_one: assert property (hit1 && pstrb == 4'hf |=> word_one == $past(pwdata)) else $error("write lost");
	chk_hold_one: assert property (!hit1 |=> $stable(word_one)) else $error("word one moved");
	chk_read_one: assert property (acc && !pwrite && paddr == ATR_ADDR_WORD_ONE |-> prdata == word_one)
		else $error("bad read");
	chk_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0000_0000)
		else $error("no refusal");
	// =====================================================
	// Decoding, one clock behind the stored word
	chk_brake_decode: assert property ($past(rst_n) |->
		decoded.brake_exit_permille == ATR_BRAKE_EXIT_PERMILLE[$past(word_one.brake_exit_sel)]) else $error("brake");
	chk_bemf_decode: assert property ($past(rst_n) |->
		decoded.handoff_min_back_emf_mv == ATR_BEMF_MV[$past(word_one.handoff_min_back_emf_sel)]) else $error("bemf");
	cover property (hit1);
	cover property (acc && !mapped);
	cover property (acc && !pwrite);
endmodule
bind atr_bank atr_bank_sva u_sva (.*);

// File: testbench/atr_bank_tb.sv
`timescale 1ns/1ps
module atr_bank_tb import atr_pkg::*; ;
	logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, w;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] word_two;
	logic [2:0] c;
	atr_word_one_type word_one;
	atr_decoded_type decoded;
	int n_errors = 0, num_checks = 0, cyc = 0;
	// Code beside the expected handoff back EMF in mV
	logic [14:0] rows [8] = '{15'h0000, 15'h1064, 15'h20c8, 15'h31f4, 15'h43e8, 15'h57d0, 15'h69c4, 15'h7bb8};
	logic [7:0] gl [4] = '{8'h00, 8'h05, 8'h0d, 8'h19};
	always #20 sys_clk = ~sys_clk;
	atr_bank DUT (.*);
	task chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			n_errors++;
			$display("BAD %0t %h %h", $time, s, x);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task give_verdict;
		if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			give_verdict;
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1;
		apb(0, ATR_ADDR_WORD_ONE, 0);
		chk(q, ATR_RST_WORD);
		for (int k = 0; k < 8; k++) begin
			c = rows[k][14:12];
			w = {1'b0, {2{c[1:0]}}, c[0], {3{c[1:0]}}, c, 6'h00, c, c[1:0], {2{c}}};
			apb(1, ATR_ADDR_WORD_ONE, w);
			apb(0, ATR_ADDR_WORD_ONE, 0);
			chk(q, w);
			chk(decoded.handoff_min_back_emf_mv, rows[k][11:0]);
			chk(decoded.brake_exit_permille, ATR_BRAKE_EXIT_PERMILLE[c[1:0]]);
			chk(decoded.glitch_cycles, gl[c[1:0]]);
			chk(decoded.quick_spin_detect_on, c[0]);
			chk(decoded.stopped_persist_ms, ATR_PERSIST_MS[c[1:0]]);
			chk(decoded.running_persist_ms, ATR_PERSIST_MS[c[1:0]]);
			chk(decoded.spin_detect_timeout_ms, ATR_TIMEOUT_MS[c[1:0]]);
			chk(decoded.estimation_current_pct, 8'(c) * 8'h0a + 8'h0a);
			chk(decoded.estimation_speed_pct, ATR_SPEED_PCT[c[1:0]]);
			chk(decoded.estimation_accel_dhz, ATR_ACCEL_DHZ[c]);
			chk(decoded.reverse_decel_pct, ATR_DECEL_PCT[c]);
		end
		apb(1, 12'h284, 32'hffff_ffff);
		chk(e, 1);
		chk(word_one, w);
		pstrb <= 4'h1;
		apb(1, ATR_ADDR_WORD_TWO, 32'h1234_5601);
		pstrb <= 4'hf;
		apb(0, ATR_ADDR_WORD_TWO, 0);
		chk(q, 32'h0000_0001);
		chk(word_two, 32'h0000_0001);
		apb(1, ATR_ADDR_STATUS, 32'hffff_ffff);
		chk(e, 1);
		apb(0, ATR_ADDR_STATUS, 0);
		chk(e, 0);
		chk(q, 32'h0000_0003);
		rst_n <= 0;
		@(posedge sys_clk);
		chk(word_one, ATR_RST_WORD);
		chk(decoded.brake_exit_permille, 0);
		rst_n <= 1;
		repeat (2) @(posedge sys_clk);
		chk(decoded.brake_exit_permille, ATR_BRAKE_EXIT_PERMILLE[0]);
		apb(0, ATR_ADDR_WORD_TWO, 0);
		chk(q, ATR_RST_WORD);
		give_verdict;
	end
endmodule
